// [verilog/pxmc_defines.vh]
// Offsets, field positions, reset values and timing counts for the port xMII/MAC config block
`ifndef PXMC_DEFINES_VH
`define PXMC_DEFINES_VH
`define PXMC_OFF_XMII_MAC 12'h300
`define PXMC_OFF_XMII_IF 12'h301
`define PXMC_OFF_STORM 12'h400
`define PXMC_OFF_FRAME 12'h401
`define PXMC_WMASK_XMII_MAC 8'h7f
`define PXMC_WMASK_XMII_IF 8'hff
`define PXMC_WMASK_STORM 8'h0b
`define PXMC_WMASK_FRAME 8'hbf
`define PXMC_RST_XMII_MAC 8'h50
`define PXMC_RST_XMII_IF 8'h08
`define PXMC_RST_STORM 8'h00
`define PXMC_RST_FRAME 8'h00
`define PXMC_BIT_DUPLEX 6
`define PXMC_BIT_TX_PAUSE 5
`define PXMC_BIT_SPEED_100 4
`define PXMC_BIT_RX_PAUSE 3
`define PXMC_BIT_NOT_1000 6
`define PXMC_BIT_RX_DELAY 4
`define PXMC_BIT_TX_DELAY 3
`define PXMC_BIT_CLK_MODE 2
`define PXMC_TYPE_HI 1
`define PXMC_TYPE_LO 0
`define PXMC_BIT_STORM 1
`define PXMC_BIT_BACKPRESS 3
`define PXMC_BIT_PASS_ALL 0
`define PXMC_TYPE_RGMII 2'h0
`define PXMC_TYPE_RMII 2'h1
`define PXMC_STRAP_SETTLE 2'h3
`define PXMC_REF_PERIOD_NS 20
`define PXMC_MII100_PERIOD_NS 40
`define PXMC_MII10_PERIOD_NS 400
`define PXMC_MII100_HALF (`PXMC_MII100_PERIOD_NS / (2 * `PXMC_REF_PERIOD_NS))
`define PXMC_MII10_HALF (`PXMC_MII10_PERIOD_NS / (2 * `PXMC_REF_PERIOD_NS))
`define PXMC_CRC_INIT 32'hffffffff
`define PXMC_CRC_POLY 32'hedb88320
`define PXMC_CRC_RESIDUE 32'hdebb20e3
`define PXMC_BCAST_BYTE 8'hff
`define PXMC_ETYPE_FC_HI 8'h88
`define PXMC_ETYPE_FC_LO 8'h08
`define PXMC_IDX_ETYPE_HI 14'h000c
`define PXMC_IDX_ETYPE_LO 14'h000d
`define PXMC_DA_BYTES 14'h0006
`endif

// [verilog/pxmc_fifo.v]
// Small receive FIFO with registered read data and valid/ready on both sides
module pxmc_fifo #(
	parameter WIDTH = 12,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	input wire clk,
	input wire rst_n,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data,
	output wire [AW:0] level
);
	localparam [31:0] DEPTH_W = DEPTH;
	localparam [31:0] ONE_W = 32'h00000001;
	localparam [AW:0] FULL = DEPTH_W[AW:0];
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_q, rd_ptr_q;
	reg [AW:0] cnt_q;
	reg out_valid_q;
	reg [WIDTH-1:0] out_data_q;
	wire push = in_valid && in_ready;
	wire pop = (cnt_q != {(AW+1){1'b0}}) && (!out_valid_q || out_ready);

	assign in_ready = cnt_q != FULL;
	assign out_valid = out_valid_q;
	assign out_data = out_data_q;
	assign level = cnt_q + {{AW{1'b0}}, out_valid_q};

	always @(posedge clk) begin
		if (push)
			mem[wr_ptr_q] <= in_data;
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
			out_valid_q <= 1'b0;
			out_data_q <= {WIDTH{1'b0}};
		end else begin
			if (push)
				wr_ptr_q <= wr_ptr_q + ONE_W[AW-1:0];
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + ONE_W[AW-1:0];
				out_data_q <= mem[rd_ptr_q];
				out_valid_q <= 1'b1;
			end else if (out_ready) begin
				out_valid_q <= 1'b0;
			end
			if (push && !pop)
				cnt_q <= cnt_q + ONE_W[AW:0];
			else if (pop && !push)
				cnt_q <= cnt_q - ONE_W[AW:0];
		end
	end
endmodule

// [verilog/pxmc_port_xmii_mac_config.v]
// Port xMII interface and switch MAC configuration with receive frame screening
`include "pxmc_defines.vh"

module pxmc_port_xmii_mac_config #(
	parameter PORT_NUM = 6,
	parameter [13:0] MIN_FRAME = 14'h0040,
	parameter [13:0] MAX_FRAME = 14'h05f2,
	parameter FIFO_DEPTH = 4,
	parameter FIFO_AW = 2
) (
	input wire REF_CLK,
	input wire RESET_N,
	input wire [11:0] REG_ADDR,
	input wire REG_WR,
	input wire REG_RD,
	input wire [7:0] REG_WDATA,
	output wire [7:0] REG_RDATA,
	input wire PORT6_SPEED_STRAP,
	input wire PORT7_SPEED_STRAP,
	input wire PORT6_CLOCKING_STRAP,
	input wire PORT7_CLOCKING_STRAP,
	input wire [1:0] PORT6_TYPE_STRAP,
	input wire [1:0] PORT7_TYPE_STRAP,
	input wire FLOW_CTRL_STRAP,
	input wire RXC_IN,
	output wire RXC_OUT,
	output wire RXC_OE,
	output wire TXC_OUT,
	output wire TXC_OE,
	input wire RX_DV,
	input wire RX_ER,
	input wire [7:0] RXD,
	input wire SWITCH_FC_FILTER,
	output wire FWD_VALID,
	input wire FWD_READY,
	output wire [7:0] FWD_DATA,
	output wire FWD_LAST,
	output wire FWD_DROP,
	output wire FWD_MIRROR_ONLY,
	output wire FWD_FC_DROP,
	output wire FWD_STORM_CHECK,
	output wire MODE_RGMII,
	output wire MODE_RMII,
	output wire MODE_MII,
	output wire SPEED_1000,
	output wire SPEED_100,
	output wire SPEED_10,
	output wire FULL_DUPLEX,
	output wire RX_CLK_DELAY_EN,
	output wire TX_CLK_DELAY_EN,
	output wire RMII_REFCLK_GEN,
	output wire TX_PAUSE_EN,
	output wire RX_PAUSE_EN,
	output wire PAUSE_REQ,
	output wire BACKPRESSURE_JAM
);
	localparam [31:0] HIGH_WATER_W = FIFO_DEPTH - 1;
	localparam [FIFO_AW:0] HIGH_WATER = HIGH_WATER_W[FIFO_AW:0];
	localparam [31:0] HALF_100_W = `PXMC_MII100_HALF;
	localparam [31:0] HALF_10_W = `PXMC_MII10_HALF;
	localparam [3:0] HALF_100 = HALF_100_W[3:0];
	localparam [3:0] HALF_10 = HALF_10_W[3:0];

	function [31:0] crc_byte;
		input [31:0] c;
		input [7:0] d;
		integer i;
		reg [31:0] r;
		begin
			r = c;
			for (i = 0; i < 8; i = i + 1) begin
				if (r[0] ^ d[i])
					r = (r >> 1) ^ `PXMC_CRC_POLY;
				else
					r = r >> 1;
			end
			crc_byte = r;
		end
	endfunction

	function is_mii;
		input [1:0] t;
		begin
			is_mii = t[`PXMC_TYPE_HI];
		end
	endfunction

	// Straps for this port, then two-stage synchroniser
	wire [4:0] strap_raw = (PORT_NUM == 7) ?
		{FLOW_CTRL_STRAP, PORT7_SPEED_STRAP, PORT7_CLOCKING_STRAP, PORT7_TYPE_STRAP} :
		{FLOW_CTRL_STRAP, PORT6_SPEED_STRAP, PORT6_CLOCKING_STRAP, PORT6_TYPE_STRAP};
	reg [4:0] strap_m_q, strap_s_q;
	reg [1:0] strap_cnt_q;
	reg strap_done_q;
	reg [7:0] xmii_port_mac_config_q;
	reg [7:0] xmii_port_interface_config_q;
	reg [7:0] port_mac_storm_config_q;
	reg [7:0] port_mac_frame_handling_config_q;
	reg [7:0] rdata_q;

	always @(posedge REF_CLK) begin
		strap_m_q <= strap_raw;
		strap_s_q <= strap_m_q;
	end

	always @(posedge REF_CLK) begin
		if (!RESET_N) begin
			strap_cnt_q <= 2'h0;
			strap_done_q <= 1'b0;
			xmii_port_mac_config_q <= `PXMC_RST_XMII_MAC;
			xmii_port_interface_config_q <= `PXMC_RST_XMII_IF;
			port_mac_storm_config_q <= `PXMC_RST_STORM;
			port_mac_frame_handling_config_q <= `PXMC_RST_FRAME;
		end else if (!strap_done_q) begin
			if (strap_cnt_q == `PXMC_STRAP_SETTLE) begin
				strap_done_q <= 1'b1;
				xmii_port_mac_config_q <= `PXMC_RST_XMII_MAC | {2'h0, strap_s_q[4], 1'b0, strap_s_q[4], 3'h0};
				xmii_port_interface_config_q <= `PXMC_RST_XMII_IF |
					{1'b0, strap_s_q[3], 3'h0, strap_s_q[2], strap_s_q[1:0]};
			end else begin
				strap_cnt_q <= strap_cnt_q + 2'h1;
			end
		end else if (REG_WR) begin
			case (REG_ADDR)
				`PXMC_OFF_XMII_MAC: xmii_port_mac_config_q <= REG_WDATA & `PXMC_WMASK_XMII_MAC;
				`PXMC_OFF_XMII_IF: xmii_port_interface_config_q <= REG_WDATA & `PXMC_WMASK_XMII_IF;
				`PXMC_OFF_STORM: port_mac_storm_config_q <= REG_WDATA & `PXMC_WMASK_STORM;
				`PXMC_OFF_FRAME: port_mac_frame_handling_config_q <= REG_WDATA & `PXMC_WMASK_FRAME;
				default: ;
			endcase
		end
	end

	always @(posedge REF_CLK) begin
		if (!RESET_N) begin
			rdata_q <= 8'h00;
		end else if (REG_RD) begin
			case (REG_ADDR)
				`PXMC_OFF_XMII_MAC: rdata_q <= xmii_port_mac_config_q;
				`PXMC_OFF_XMII_IF: rdata_q <= xmii_port_interface_config_q;
				`PXMC_OFF_STORM: rdata_q <= port_mac_storm_config_q;
				`PXMC_OFF_FRAME: rdata_q <= port_mac_frame_handling_config_q;
				default: rdata_q <= 8'h00;
			endcase
		end
	end
	assign REG_RDATA = rdata_q;

	// Link pins through two flip-flops
	wire [10:0] pin_raw = {RXC_IN, RX_DV, RX_ER, RXD};
	reg [10:0] pin_m_q, pin_s_q;
	always @(posedge REF_CLK) begin
		pin_m_q <= pin_raw;
		pin_s_q <= pin_m_q;
	end
	wire rx_dv = pin_s_q[9];
	wire rx_er = pin_s_q[8];
	wire [7:0] rx_d = pin_s_q[7:0];

	// Applied configuration
	reg rgmii_q, rmii_q, mii_q, sp1000_q, sp100_q, sp10_q, fdx_q;
	reg rxdly_q, txdly_q, clk_in_q, txfc_q, rxfc_q;
	reg in_frame_q, tail_q;
	wire [1:0] if_type = xmii_port_interface_config_q[`PXMC_TYPE_HI:`PXMC_TYPE_LO];
	wire not_1000 = xmii_port_interface_config_q[`PXMC_BIT_NOT_1000];
	wire speed_100 = xmii_port_mac_config_q[`PXMC_BIT_SPEED_100];
	wire cfg_idle = !in_frame_q && !rx_dv && !tail_q;

	always @(posedge REF_CLK) begin
		if (!RESET_N) begin
			rgmii_q <= 1'b1;
			rmii_q <= 1'b0;
			mii_q <= 1'b0;
			sp1000_q <= 1'b1;
			sp100_q <= 1'b0;
			sp10_q <= 1'b0;
			fdx_q <= 1'b1;
			rxdly_q <= 1'b0;
			txdly_q <= 1'b1;
			clk_in_q <= 1'b0;
			txfc_q <= 1'b0;
			rxfc_q <= 1'b0;
		end else if (cfg_idle) begin
			rgmii_q <= if_type == `PXMC_TYPE_RGMII;
			rmii_q <= if_type == `PXMC_TYPE_RMII;
			mii_q <= is_mii(if_type);
			sp1000_q <= !not_1000;
			sp100_q <= not_1000 && speed_100;
			sp10_q <= not_1000 && !speed_100;
			fdx_q <= xmii_port_mac_config_q[`PXMC_BIT_DUPLEX];
			rxdly_q <= (if_type == `PXMC_TYPE_RGMII) && xmii_port_interface_config_q[`PXMC_BIT_RX_DELAY];
			txdly_q <= (if_type == `PXMC_TYPE_RGMII) && xmii_port_interface_config_q[`PXMC_BIT_TX_DELAY];
			clk_in_q <= xmii_port_interface_config_q[`PXMC_BIT_CLK_MODE];
			txfc_q <= xmii_port_mac_config_q[`PXMC_BIT_TX_PAUSE];
			rxfc_q <= xmii_port_mac_config_q[`PXMC_BIT_RX_PAUSE];
		end
	end

	// Clock divider for MII PHY mode
	reg [3:0] div_cnt_q;
	reg div_q;
	wire [3:0] div_half = sp100_q ? HALF_100 : HALF_10;
	wire drive_mii = mii_q && !clk_in_q;
	always @(posedge REF_CLK) begin
		if (!RESET_N || !drive_mii) begin
			div_cnt_q <= 4'h1;
			div_q <= 1'b0;
		end else if (div_cnt_q >= div_half) begin
			div_cnt_q <= 4'h1;
			div_q <= !div_q;
		end else begin
			div_cnt_q <= div_cnt_q + 4'h1;
		end
	end
	assign RXC_OUT = div_q;
	assign TXC_OUT = div_q;
	assign TXC_OE = drive_mii;
	assign RXC_OE = drive_mii || (rmii_q && !clk_in_q);
	assign RMII_REFCLK_GEN = rmii_q && !clk_in_q;

	// Receive sampling edge
	reg rclk_prev_q;
	wire rclk = drive_mii ? div_q : pin_s_q[10];
	wire rx_edge = rmii_q ? 1'b1 : (rclk && !rclk_prev_q);
	always @(posedge REF_CLK) begin
		if (!RESET_N)
			rclk_prev_q <= 1'b0;
		else
			rclk_prev_q <= rclk;
	end

	// Frame screening
	reg have_q, err_q, ovf_q, bcast_q, fc_hi_q, fc_q;
	reg [7:0] pend_q;
	reg [31:0] crc_q;
	reg [13:0] cnt_q;
	reg [11:0] tail_w_q;
	wire in_ready;
	wire [FIFO_AW:0] fifo_level;
	wire data_push = rx_edge && rx_dv && in_frame_q && have_q && !tail_q;
	wire push_v = tail_q || data_push;
	wire [11:0] push_w = tail_q ? tail_w_q : {4'h0, pend_q};
	wire frame_end = rx_edge && !rx_dv && in_frame_q;
	wire bad_now = err_q || ovf_q || (crc_q != `PXMC_CRC_RESIDUE) ||
		(cnt_q < MIN_FRAME) || (cnt_q > MAX_FRAME);
	wire [31:0] crc_src = in_frame_q ? crc_q : `PXMC_CRC_INIT;

	always @(posedge REF_CLK) begin
		if (!RESET_N) begin
			in_frame_q <= 1'b0;
			have_q <= 1'b0;
			pend_q <= 8'h00;
			crc_q <= `PXMC_CRC_INIT;
			cnt_q <= 14'h0000;
			err_q <= 1'b0;
			ovf_q <= 1'b0;
			bcast_q <= 1'b0;
			fc_hi_q <= 1'b0;
			fc_q <= 1'b0;
			tail_q <= 1'b0;
			tail_w_q <= 12'h000;
		end else begin
			if (tail_q && in_ready)
				tail_q <= 1'b0;
			if (frame_end) begin
				in_frame_q <= 1'b0;
				have_q <= 1'b0;
				tail_q <= 1'b1;
				tail_w_q <= {fc_q, bcast_q, bad_now, 1'b1, pend_q};
			end else if (rx_edge && rx_dv) begin
				in_frame_q <= 1'b1;
				have_q <= 1'b1;
				pend_q <= rx_d;
				crc_q <= crc_byte(crc_src, rx_d);
				if (cnt_q != 14'h3fff || !in_frame_q)
					cnt_q <= in_frame_q ? cnt_q + 14'h0001 : 14'h0001;
				err_q <= (in_frame_q && err_q) || rx_er;
				if (!in_frame_q)
					bcast_q <= rx_d == `PXMC_BCAST_BYTE;
				else if (cnt_q < `PXMC_DA_BYTES)
					bcast_q <= bcast_q && (rx_d == `PXMC_BCAST_BYTE);
				if (!in_frame_q)
					fc_q <= 1'b0;
				if (in_frame_q && cnt_q == `PXMC_IDX_ETYPE_HI)
					fc_hi_q <= rx_d == `PXMC_ETYPE_FC_HI;
				if (in_frame_q && cnt_q == `PXMC_IDX_ETYPE_LO)
					fc_q <= fc_hi_q && (rx_d == `PXMC_ETYPE_FC_LO);
				// Overflow or a stalled tail loses bytes: frame marked bad
				if (!in_frame_q)
					ovf_q <= 1'b0;
				else if (have_q && (tail_q || !in_ready))
					ovf_q <= 1'b1;
			end
		end
	end

	wire [11:0] fwd_w;
	pxmc_fifo #(
		.WIDTH(12),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.clk(REF_CLK),
		.rst_n(RESET_N),
		.in_valid(push_v),
		.in_ready(in_ready),
		.in_data(push_w),
		.out_valid(FWD_VALID),
		.out_ready(FWD_READY),
		.out_data(fwd_w),
		.level(fifo_level)
	);

	wire pass_all = port_mac_frame_handling_config_q[`PXMC_BIT_PASS_ALL];
	wire bp_en = port_mac_frame_handling_config_q[`PXMC_BIT_BACKPRESS];
	wire storm_en = port_mac_storm_config_q[`PXMC_BIT_STORM];
	wire high_water = fifo_level >= HIGH_WATER;

	assign FWD_DATA = fwd_w[7:0];
	assign FWD_LAST = fwd_w[8];
	assign FWD_DROP = fwd_w[8] && fwd_w[9] && !pass_all;
	assign FWD_MIRROR_ONLY = fwd_w[8] && fwd_w[9] && pass_all;
	assign FWD_FC_DROP = fwd_w[8] && fwd_w[11] && SWITCH_FC_FILTER;
	assign FWD_STORM_CHECK = fwd_w[8] && fwd_w[10] && storm_en;
	assign BACKPRESSURE_JAM = bp_en && !fdx_q && high_water;
	assign PAUSE_REQ = fdx_q && txfc_q && high_water;
	assign TX_PAUSE_EN = fdx_q && txfc_q;
	assign RX_PAUSE_EN = fdx_q && rxfc_q;

	assign MODE_RGMII = rgmii_q;
	assign MODE_RMII = rmii_q;
	assign MODE_MII = mii_q;
	assign SPEED_1000 = sp1000_q;
	assign SPEED_100 = sp100_q;
	assign SPEED_10 = sp10_q;
	assign FULL_DUPLEX = fdx_q;
	assign RX_CLK_DELAY_EN = rxdly_q;
	assign TX_CLK_DELAY_EN = txdly_q;
endmodule

// [dv/pxmc_link_model.sv]
// Far-side link model: MAC-mode clock source driving byte-lane receive frames
module pxmc_link_model (
	output logic rxc,
	output logic dv,
	output logic er,
	output logic [7:0] data
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int HALF_NS = 80;
	logic [7:0] fbytes [0:127];
	initial begin
		rxc = 1'b0;
		dv = 1'b0;
		er = 1'b0;
		data = 8'h00;
	end
	// Clock stands low between frames; idle data is flipped so stale bytes never look valid
	task automatic send(input int n, input bit bad_sym);
		for (int i = 0; i < n; i++) begin
			dv = 1'b1;
			er = bad_sym && (i == 5);
			data = fbytes[i];
			#HALF_NS rxc = 1'b1;
			#HALF_NS rxc = 1'b0;
		end
		dv = 1'b0;
		er = 1'b0;
		data = ~data;
		#HALF_NS rxc = 1'b1;
		#HALF_NS rxc = 1'b0;
	endtask
endmodule

// [dv/pxmc_port_xmii_mac_config_chk.sv]
// Checker for the port config block: register answers, mode decode, stream hold and flags
module pxmc_port_xmii_mac_config_chk (
	input wire REF_CLK,
	input wire RESET_N,
	input wire [11:0] REG_ADDR,
	input wire REG_RD,
	input wire [7:0] REG_RDATA,
	input wire RX_DV,
	input wire FWD_VALID,
	input wire FWD_READY,
	input wire [7:0] FWD_DATA,
	input wire FWD_LAST,
	input wire FWD_DROP,
	input wire FWD_MIRROR_ONLY,
	input wire MODE_RGMII,
	input wire MODE_RMII,
	input wire MODE_MII,
	input wire SPEED_1000,
	input wire SPEED_100,
	input wire SPEED_10,
	input wire FULL_DUPLEX,
	input wire RX_CLK_DELAY_EN,
	input wire TX_CLK_DELAY_EN,
	input wire RMII_REFCLK_GEN,
	input wire PAUSE_REQ,
	input wire BACKPRESSURE_JAM
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);
	sequence s_stalled;
		FWD_VALID && !FWD_READY;
	endsequence
	sequence s_in_frame;
		RX_DV [*8];
	endsequence
	sequence s_tail;
		FWD_VALID && FWD_LAST;
	endsequence
	a_unmapped_read_zero: assert property (REG_RD && !(REG_ADDR inside {12'h300, 12'h301, 12'h400, 12'h401})
		|=> REG_RDATA == 8'h00) else $error("unmapped read not zero");
	a_mode_one_hot: assert property ($onehot({MODE_RGMII, MODE_RMII, MODE_MII}))
		else $error("interface mode not one-hot");
	a_speed_one_hot: assert property ($onehot({SPEED_1000, SPEED_100, SPEED_10}))
		else $error("speed not one-hot");
	a_delay_rgmii_only: assert property (RX_CLK_DELAY_EN || TX_CLK_DELAY_EN |-> MODE_RGMII)
		else $error("clock delay outside RGMII");
	a_refclk_rmii_only: assert property (RMII_REFCLK_GEN |-> MODE_RMII)
		else $error("reference clock generated outside RMII");
	a_jam_half_only: assert property (BACKPRESSURE_JAM |-> !FULL_DUPLEX)
		else $error("back pressure in full duplex");
	a_pause_full_only: assert property (PAUSE_REQ |-> FULL_DUPLEX)
		else $error("pause request in half duplex");
	a_bad_one_way: assert property (s_tail |-> !(FWD_DROP && FWD_MIRROR_ONLY))
		else $error("frame both dropped and mirrored");
	a_stream_holds: assert property (s_stalled |=> FWD_VALID && $stable(FWD_DATA) && $stable(FWD_LAST))
		else $error("stalled stream word changed");
	a_config_frozen: assert property (s_in_frame |=> $stable({MODE_RGMII, MODE_RMII, MODE_MII, SPEED_1000,
		SPEED_100, SPEED_10})) else $error("config changed inside frame");
endmodule

bind pxmc_port_xmii_mac_config pxmc_port_xmii_mac_config_chk i_pxmc_port_xmii_mac_config_chk (.REF_CLK,
	.RESET_N, .REG_ADDR, .REG_RD, .REG_RDATA, .RX_DV, .FWD_VALID, .FWD_READY, .FWD_DATA, .FWD_LAST, .FWD_DROP,
	.FWD_MIRROR_ONLY, .MODE_RGMII, .MODE_RMII, .MODE_MII, .SPEED_1000, .SPEED_100, .SPEED_10, .FULL_DUPLEX,
	.RX_CLK_DELAY_EN, .TX_CLK_DELAY_EN, .RMII_REFCLK_GEN, .PAUSE_REQ, .BACKPRESSURE_JAM);

// [dv/pxmc_port_xmii_mac_config_bench.sv]
// Bench for the port config block: registers, mode decode and receive screening
module pxmc_port_xmii_mac_config_bench;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {int n; logic [7:0] r400; logic [7:0] r401; logic [4:0] kind; logic [3:0] fl;} pxmc_frm_t;
	logic REF_CLK = 1'b0;
	logic RESET_N = 1'b0;
	logic REG_WR = 1'b0;
	logic REG_RD = 1'b0;
	logic FWD_READY = 1'b1;
	logic SWITCH_FC_FILTER = 1'b0;
	logic [11:0] REG_ADDR = 12'h000;
	logic [7:0] REG_WDATA = 8'h00;
	logic [1:0] PORT6_TYPE_STRAP = 2'h2;
	logic PORT6_SPEED_STRAP = 1'b1;
	logic PORT6_CLOCKING_STRAP = 1'b1;
	wire [7:0] REG_RDATA, RXD, FWD_DATA;
	wire RXC_IN, RX_DV, RX_ER, FWD_VALID, FWD_LAST, FWD_DROP, FWD_MIRROR_ONLY, FWD_FC_DROP, FWD_STORM_CHECK;
	wire MODE_RGMII, MODE_RMII, MODE_MII, SPEED_1000, SPEED_100, SPEED_10, FULL_DUPLEX, RX_CLK_DELAY_EN;
	wire TX_CLK_DELAY_EN, RMII_REFCLK_GEN, RXC_OE, TXC_OE, PAUSE_REQ, BACKPRESSURE_JAM;
	wire RXC_OUT, TXC_OUT, TX_PAUSE_EN, RX_PAUSE_EN;
	int n_errors = 0;
	int total_checks = 0;
	logic [1:0] clk_s;
	localparam logic [7:0] T300 [6] = '{8'h50, 8'h40, 8'h50, 8'h10, 8'h50, 8'hd0};
	localparam logic [7:0] T301 [6] = '{8'h58, 8'h41, 8'h4e, 8'h4b, 8'h45, 8'hce};
	// Length limit set to 100 so the oversize boundary stays short
	pxmc_frm_t ft [10] = '{
		'{100, 8'h00, 8'h00, 5'h00, 4'h0},
		'{101, 8'h00, 8'h00, 5'h00, 4'h8},
		'{64, 8'h00, 8'h00, 5'h02, 4'h8},
		'{64, 8'h00, 8'h01, 5'h02, 4'h4},
		'{63, 8'h00, 8'h01, 5'h00, 4'h4},
		'{64, 8'h00, 8'h00, 5'h01, 4'h8},
		'{64, 8'h00, 8'h01, 5'h14, 4'h2},
		'{64, 8'h00, 8'h00, 5'h04, 4'h0},
		'{64, 8'h00, 8'h00, 5'h08, 4'h0},
		'{64, 8'h02, 8'h00, 5'h08, 4'h1}};
	pxmc_port_xmii_mac_config #(.MAX_FRAME(14'h0064)) i_pxmc_port_xmii_mac_config (
		.REF_CLK, .RESET_N, .REG_ADDR, .REG_WR, .REG_RD, .REG_WDATA, .REG_RDATA, .PORT6_SPEED_STRAP,
		.PORT7_SPEED_STRAP(1'b0), .PORT6_CLOCKING_STRAP, .PORT7_CLOCKING_STRAP(1'b0), .PORT6_TYPE_STRAP,
		.PORT7_TYPE_STRAP(2'h0), .FLOW_CTRL_STRAP(1'b0), .RXC_IN, .RXC_OUT, .RXC_OE, .TXC_OUT, .TXC_OE,
		.RX_DV, .RX_ER, .RXD, .SWITCH_FC_FILTER, .FWD_VALID, .FWD_READY, .FWD_DATA, .FWD_LAST, .FWD_DROP,
		.FWD_MIRROR_ONLY, .FWD_FC_DROP, .FWD_STORM_CHECK, .MODE_RGMII, .MODE_RMII, .MODE_MII, .SPEED_1000,
		.SPEED_100, .SPEED_10, .FULL_DUPLEX, .RX_CLK_DELAY_EN, .TX_CLK_DELAY_EN, .RMII_REFCLK_GEN,
		.TX_PAUSE_EN, .RX_PAUSE_EN, .PAUSE_REQ, .BACKPRESSURE_JAM);
	pxmc_link_model i_pxmc_link_model (.rxc(RXC_IN), .dv(RX_DV), .er(RX_ER), .data(RXD));
	always #10 REF_CLK = ~REF_CLK;
	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic cb(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %0t byte %h expected %h", $time, g, e);
		end
	endtask
	task automatic cv(input logic [11:0] g, input logic [11:0] e);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %0t flags %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		REG_ADDR = a;
		REG_WDATA = d;
		REG_WR = 1'b1;
		@(posedge REF_CLK);
		#1 REG_WR = 1'b0;
		@(posedge REF_CLK);
		#1;
	endtask
	task automatic rc(input logic [11:0] a, input logic [7:0] e);
		REG_ADDR = a;
		REG_RD = 1'b1;
		@(posedge REF_CLK);
		#1 REG_RD = 1'b0;
		@(posedge REF_CLK);
		#1 cb(REG_RDATA, e);
	endtask
	function automatic logic [11:0] exp_cfg(input logic [7:0] m, input logic [7:0] x);
		logic rg, rm, mi;
		rg = x[1:0] == 2'h0;
		rm = x[1:0] == 2'h1;
		mi = x[1];
		return {rg, rm, mi, !x[6], x[6] & m[4], x[6] & !m[4], x[4] & rg, x[3] & rg, m[6], rm & !x[2], {2{mi & !x[2]}}};
	endfunction
	// Frame with reflected CRC32 FCS sent low byte first; k is broadcast, flow control, corrupt FCS
	task automatic build(input int n, input logic [2:0] k);
		logic [31:0] c;
		logic [7:0] b;
		c = 32'hffffffff;
		for (int i = 0; i < n - 4; i++) begin
			b = 8'(i) + 8'h11;
			if (k[2] && i < 6) b = 8'hff;
			if (k[1] && i == 12) b = 8'h88;
			if (k[1] && i == 13) b = 8'h08;
			i_pxmc_link_model.fbytes[i] = b;
			c = c ^ {24'h0, b};
			repeat (8) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
		end
		c = ~c ^ {31'h0, k[0]};
		for (int i = 0; i < 4; i++)
			i_pxmc_link_model.fbytes[n - 4 + i] = c[8 * i +: 8];
	endtask
	task automatic recv(input int stall, input logic [3:0] fl, input logic [1:0] pr, input bit dchk);
		int cnt;
		cnt = 0;
		for (int t = 0; t < 3000; t++) begin
			FWD_READY = t >= stall;
			if (stall > 0 && t == stall - 1)
				cv({10'h0, BACKPRESSURE_JAM, PAUSE_REQ}, {10'h0, pr});
			if (FWD_VALID === 1'b1 && FWD_READY) begin
				if (dchk)
					cb(FWD_DATA, i_pxmc_link_model.fbytes[cnt]);
				cnt++;
				if (FWD_LAST === 1'b1) begin
					cv({8'h0, FWD_DROP, FWD_MIRROR_ONLY, FWD_FC_DROP, FWD_STORM_CHECK}, {8'h0, fl});
					@(posedge REF_CLK);
					#1;
					return;
				end
			end
			@(posedge REF_CLK);
			#1;
		end
		n_errors++;
		$display("[FAIL] %0t no frame tail", $time);
		print_verdict();
	endtask
	initial begin
		repeat (5) @(posedge REF_CLK);
		#1 RESET_N = 1'b1;
		repeat (8) @(posedge REF_CLK);
		#1;
		rc(12'h300, 8'h50);
		rc(12'h301, 8'h4e);
		rc(12'h400, 8'h00);
		rc(12'h401, 8'h00);
		wr(12'h400, 8'hff);
		rc(12'h400, 8'h0b);
		wr(12'h401, 8'hff);
		rc(12'h401, 8'hbf);
		wr(12'h302, 8'hff);
		rc(12'h302, 8'h00);
		for (int i = 0; i < 6; i++) begin
			wr(12'h300, T300[i]);
			wr(12'h301, T301[i]);
			rc(12'h300, T300[i] & 8'h7f);
			rc(12'h301, T301[i]);
			cv({MODE_RGMII, MODE_RMII, MODE_MII, SPEED_1000, SPEED_100, SPEED_10, RX_CLK_DELAY_EN, TX_CLK_DELAY_EN,
				FULL_DUPLEX, RMII_REFCLK_GEN, RXC_OE & MODE_MII, TXC_OE & MODE_MII},
				exp_cfg(T300[i], T301[i]));
			// Every PHY-mode row runs at 100 Mb/s, so a driven clock flips each cycle
			clk_s = {RXC_OUT, TXC_OUT};
			@(posedge REF_CLK);
			#1 cv({10'h0, clk_s ^ {RXC_OUT, TXC_OUT}}, {10'h0, {2{T301[i][1] & !T301[i][2]}}});
		end
		for (int i = 0; i < 10; i++) begin
			wr(12'h400, ft[i].r400);
			wr(12'h401, ft[i].r401);
			SWITCH_FC_FILTER = ft[i].kind[4];
			build(ft[i].n, ft[i].kind[3:1]);
			fork
				i_pxmc_link_model.send(ft[i].n, ft[i].kind[0]);
				recv(0, ft[i].fl, 2'h0, 1'b1);
			join
		end
		for (int i = 0; i < 2; i++) begin
			wr(12'h300, i ? 8'h78 : 8'h38);
			wr(12'h401, 8'h08);
			cv({10'h0, TX_PAUSE_EN, RX_PAUSE_EN}, i ? 12'h003 : 12'h000);
			build(64, 3'h0);
			fork
				i_pxmc_link_model.send(64, 1'b0);
				recv(200, 4'h8, i ? 2'h1 : 2'h2, 1'b0);
				if (i) begin
					// Speed change lands mid-frame and must wait for the tail
					repeat (100) @(posedge REF_CLK);
					#1 wr(12'h301, 8'h0e);
					cv({10'h0, SPEED_1000, SPEED_100}, 12'h001);
				end
			join
			cv({10'h0, SPEED_1000, SPEED_100}, i ? 12'h002 : 12'h001);
		end
		print_verdict();
	end
endmodule
